/* File: src/mgp_pkg.sv */
// package for the masked gpio port data path: register map, field layout,
// reset values and port geometry shared by the top, its checker and its bench.
// assumes a plain address/strobe register port and eight identical ports.
package mgp_pkg;

	// ==========================================================================
	// geometry
	localparam int PORT_COUNT = 8;
	localparam int PIN_COUNT  = 8;
	localparam int ADDR_W     = 15;
	localparam int DATA_W     = 32;
	localparam int PSEL_W     = 3;

	// ==========================================================================
	// address fields: port index above a 4 KB window per port
	localparam int PORT_SEL_LSB = 12;
	localparam int OFFSET_W     = 12;
	localparam int MASK_LSB     = 2;
	localparam int DATA_WIN_LSB = 10;

	// ==========================================================================
	// register offsets inside one port window
	localparam logic [11:0] OFF_DATA_BASE = 12'h000;
	localparam logic [11:0] OFF_DIR       = 12'h400;
	localparam logic [11:0] OFF_AFSEL     = 12'h420;
	localparam logic [11:0] OFF_PULL_UP   = 12'h510;
	localparam logic [11:0] OFF_PULL_DOWN = 12'h514;
	localparam logic [11:0] OFF_DIG_EN    = 12'h51C;
	localparam logic [11:0] OFF_PIN_LEVEL = 12'h600;

	// ==========================================================================
	// debug pin placement: port b bit 7, port c bits 3:0
	localparam int          PORT_B_IDX     = 1;
	localparam int          PORT_C_IDX     = 2;
	localparam int          PORT_B_BIT7    = 7;
	localparam logic [7:0]  DEBUG_MASK_B   = 8'h80;
	localparam logic [7:0]  DEBUG_MASK_C   = 8'h0F;
	localparam logic [7:0]  ORDINARY_RESET = 8'h00;

	// ==========================================================================
	// reset value of afsel, digital enable and pull-up for a given port
	function automatic logic [7:0] mgp_debug_reset(input int port);
		logic [7:0] val;
		val = ORDINARY_RESET;
		if (port == PORT_B_IDX) begin
			val = DEBUG_MASK_B;
		end
		if (port == PORT_C_IDX) begin
			val = DEBUG_MASK_C;
		end
		return val;
	endfunction

endpackage

/* File: src/mgp_pin_sync.sv */
// two-stage synchroniser for one port's worth of pad inputs.
// assumes pads change asynchronously to clk_sys; only stage two is read.
// both stages reset to the idle level that the pulls give each pad.
`timescale 1ns/10ps
module mgp_pin_sync #(
	parameter int               WIDTH     = 8,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] pin_async,
	output logic      [WIDTH-1:0] pin_sync
);

	// ==========================================================================
	// first stage feeds only the second stage, nothing else taps it
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			meta     <= RESET_VAL;
			pin_sync <= RESET_VAL;
		end else begin
			meta     <= pin_async;
			pin_sync <= meta;
		end
	end

endmodule

/* File: src/mgp_top.sv */
// eight identical gpio ports with direction control, masked data access,
// alternate-function hand-over and debug-pin reset defaults.
// assumes a one-cycle strobe register port on clk_sys and asynchronous pads.
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/10ps
module mgp_top #(
	parameter int PORTS = mgp_pkg::PORT_COUNT,
	parameter int PINS  = mgp_pkg::PIN_COUNT
) (
	input  wire logic                         clk_sys,
	input  wire logic                         rst_b,
	input  wire logic [mgp_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [mgp_pkg::DATA_W-1:0]   reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [mgp_pkg::DATA_W-1:0]   reg_rdata,
	input  wire logic [PORTS*PINS-1:0]        pad_in,
	output logic      [PORTS*PINS-1:0]        pad_out,
	output logic      [PORTS*PINS-1:0]        pad_oe_b,
	output logic      [PORTS*PINS-1:0]        pad_pull_up,
	output logic      [PORTS*PINS-1:0]        pad_pull_down,
	input  wire logic [PORTS*PINS-1:0]        periph_out,
	input  wire logic [PORTS*PINS-1:0]        periph_oe,
	output logic      [PORTS*PINS-1:0]        periph_in,
	output logic                              debug_reset_b
);

	// ==========================================================================
	// per-port configuration and data storage, one flop row per port

	logic [PINS-1:0] pin_direction         [PORTS];
	logic [PINS-1:0] alt_function_select   [PORTS];
	logic [PINS-1:0] digital_input_enable  [PORTS];
	logic [PINS-1:0] pull_up_select        [PORTS];
	logic [PINS-1:0] pull_down_select      [PORTS];
	logic [PINS-1:0] pin_value_register    [PORTS];
	logic [PINS-1:0] pin_level             [PORTS];

	// ==========================================================================
	// address decode

	logic [mgp_pkg::PSEL_W-1:0]   port_sel;
	logic [mgp_pkg::OFFSET_W-1:0] reg_offset;
	logic [PINS-1:0]              access_mask;
	logic                         hit_data;
	logic                         hit_dir;
	logic                         hit_afsel;
	logic                         hit_pull_up;
	logic                         hit_pull_down;
	logic                         hit_dig_en;
	logic                         hit_pin_level;

	// port index sits above the per-port 4 KB window
	assign port_sel   = reg_addr[mgp_pkg::PORT_SEL_LSB +: mgp_pkg::PSEL_W];
	assign reg_offset = reg_addr[mgp_pkg::OFFSET_W-1:0];

	// mask bit mapping
	// byte-address bits 1:0 are ignored, bit n+2 gates data bit n
	assign access_mask = reg_addr[mgp_pkg::MASK_LSB +: PINS];

	// data window decode
	// every word from offset 0x000 to 0x3FC aliases the same data register
	assign hit_data      = (reg_offset[mgp_pkg::OFFSET_W-1:mgp_pkg::DATA_WIN_LSB] == 2'h0);
	assign hit_dir       = (reg_offset == mgp_pkg::OFF_DIR);
	assign hit_afsel     = (reg_offset == mgp_pkg::OFF_AFSEL);
	assign hit_pull_up   = (reg_offset == mgp_pkg::OFF_PULL_UP);
	assign hit_pull_down = (reg_offset == mgp_pkg::OFF_PULL_DOWN);
	assign hit_dig_en    = (reg_offset == mgp_pkg::OFF_DIG_EN);
	assign hit_pin_level = (reg_offset == mgp_pkg::OFF_PIN_LEVEL);

	// ==========================================================================
	// eight identical ports
	// each port owns its synchroniser and its own register row

	genvar gp;
	generate
		for (gp = 0; gp < PORTS; gp++) begin : g_port
			logic [PINS-1:0] sync_level;
			logic            wr_here;

			// pulled debug pins start from their idle high level; a zero
			// reset value would look like a low pin and pulse the debug
			// reset right after every reset release
			mgp_pin_sync #(
				.WIDTH     (PINS),
				.RESET_VAL (mgp_pkg::mgp_debug_reset(gp))
			) u_sync (
				.clk_sys   (clk_sys),
				.rst_b     (rst_b),
				.pin_async (pad_in[gp*PINS +: PINS]),
				.pin_sync  (sync_level)
			);

			// a write lands only in the port that the index selects
			assign wr_here = reg_wr && (int'(port_sel) == gp);

			// synchronised pad level, visible to software and peripherals
			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					pin_level[gp] <= mgp_pkg::mgp_debug_reset(gp);
				end else begin
					pin_level[gp] <= sync_level;
				end
			end

			// afsel reset defaults
			// any reset reloads the debug pattern, ordinary pins clear
			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					alt_function_select[gp] <= mgp_pkg::mgp_debug_reset(gp);
				end else if (wr_here && hit_afsel) begin
					alt_function_select[gp] <= reg_wdata[PINS-1:0];
				end
			end

			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					digital_input_enable[gp] <= mgp_pkg::mgp_debug_reset(gp);
				end else if (wr_here && hit_dig_en) begin
					digital_input_enable[gp] <= reg_wdata[PINS-1:0];
				end
			end

			// pull-up reset defaults
			// debug pins keep their pull-up so a floating line reads idle
			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					pull_up_select[gp] <= mgp_pkg::mgp_debug_reset(gp);
				end else if (wr_here && hit_pull_up) begin
					pull_up_select[gp] <= reg_wdata[PINS-1:0];
				end
			end

			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					pull_down_select[gp] <= mgp_pkg::ORDINARY_RESET;
				end else if (wr_here && hit_pull_down) begin
					pull_down_select[gp] <= reg_wdata[PINS-1:0];
				end
			end

			// direction: zero means input after reset on every pin
			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					pin_direction[gp] <= mgp_pkg::ORDINARY_RESET;
				end else if (wr_here && hit_dir) begin
					pin_direction[gp] <= reg_wdata[PINS-1:0];
				end
			end

			// data register per bit
			// inputs track the pad gated by digital enable each cycle and win over writes, so a write to an input
			// bit is dropped; outputs keep the written value
			for (genvar gb = 0; gb < PINS; gb++) begin : g_bit
				always_ff @(posedge clk_sys or negedge rst_b) begin
					if (!rst_b) begin
						pin_value_register[gp][gb] <= 1'b0;
					end else if (!pin_direction[gp][gb]) begin
						pin_value_register[gp][gb] <= sync_level[gb] & digital_input_enable[gp][gb];
					end else if (wr_here && hit_data && access_mask[gb]) begin
						pin_value_register[gp][gb] <= reg_wdata[gb];
					end
				end
			end
		end
	endgenerate

	// ==========================================================================
	// pad drive, registered so every pad output comes from a flop

	logic [PORTS*PINS-1:0] next_pad_out;
	logic [PORTS*PINS-1:0] next_pad_oe_b;
	logic [PORTS*PINS-1:0] next_periph_in;
	logic [PORTS*PINS-1:0] next_pull_up;
	logic [PORTS*PINS-1:0] next_pull_down;

	// pin owner select
	// afsel hands data and enable to the peripheral, otherwise software owns
	// the pin through direction and data; a disabled digital path never drives
	always_comb begin
		next_pad_out   = '0;
		next_pad_oe_b  = '1;
		next_periph_in = '0;
		next_pull_up   = '0;
		next_pull_down = '0;
		for (int p = 0; p < PORTS; p++) begin
			for (int b = 0; b < PINS; b++) begin
				if (alt_function_select[p][b]) begin
					next_pad_out[p*PINS+b]  = periph_out[p*PINS+b];
					next_pad_oe_b[p*PINS+b] = !(periph_oe[p*PINS+b] && digital_input_enable[p][b]);
				end else begin
					next_pad_out[p*PINS+b]  = pin_value_register[p][b];
					next_pad_oe_b[p*PINS+b] = !(pin_direction[p][b] && digital_input_enable[p][b]);
				end
				next_periph_in[p*PINS+b] = pin_level[p][b] & digital_input_enable[p][b];
				next_pull_up[p*PINS+b]   = pull_up_select[p][b];
				next_pull_down[p*PINS+b] = pull_down_select[p][b];
			end
		end
	end

	// pads undriven in reset
	// enables reset high, so nothing drives before software, or on the debug pins the peripheral, asks for it
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pad_out  <= '0;
			pad_oe_b <= '1;
		end else begin
			pad_out  <= next_pad_out;
			pad_oe_b <= next_pad_oe_b;
		end
	end

	// debug pull-ups at reset
	// pull pattern is known during reset, matching the afsel defaults
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (int p = 0; p < PORTS; p++) begin
				pad_pull_up[p*PINS +: PINS]   <= mgp_pkg::mgp_debug_reset(p);
				pad_pull_down[p*PINS +: PINS] <= mgp_pkg::ORDINARY_RESET;
			end
		end else begin
			pad_pull_up   <= next_pull_up;
			pad_pull_down <= next_pull_down;
		end
	end

	// peripheral view of the pads, gated by digital enable
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			periph_in <= '0;
		end else begin
			periph_in <= next_periph_in;
		end
	end

	// ==========================================================================
	// debug reset from port b bit 7
	// low on the synchronised pin resets the debug controller while the pin
	// is in its debug function; in gpio mode the reset is held inactive.
	// a board that pulls this pin low during reset loses the debug link.

	logic next_debug_reset_b;

	assign next_debug_reset_b =
		!(alt_function_select[mgp_pkg::PORT_B_IDX][mgp_pkg::PORT_B_BIT7] &&
		  !pin_level[mgp_pkg::PORT_B_IDX][mgp_pkg::PORT_B_BIT7]);

	// reset value inactive; the pin needs three cycles to reach the flop
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			debug_reset_b <= 1'b1;
		end else begin
			debug_reset_b <= next_debug_reset_b;
		end
	end

	// ==========================================================================
	// read path: data stands in the cycle after the strobe only

	logic [PINS-1:0]            read_byte;
	logic [mgp_pkg::DATA_W-1:0] next_rdata;
	logic [PINS-1:0]            sel_dir;
	logic [PINS-1:0]            sel_afsel;
	logic [PINS-1:0]            sel_pull_up;
	logic [PINS-1:0]            sel_pull_down;
	logic [PINS-1:0]            sel_dig_en;
	logic [PINS-1:0]            sel_data;
	logic [PINS-1:0]            sel_level;

	// pick the addressed port's row before the offset mux
	always_comb begin
		sel_dir       = '0;
		sel_afsel     = '0;
		sel_pull_up   = '0;
		sel_pull_down = '0;
		sel_dig_en    = '0;
		sel_data      = '0;
		sel_level     = '0;
		for (int p = 0; p < PORTS; p++) begin
			if (port_sel == p[mgp_pkg::PSEL_W-1:0]) begin
				sel_dir       = pin_direction[p];
				sel_afsel     = alt_function_select[p];
				sel_pull_up   = pull_up_select[p];
				sel_pull_down = pull_down_select[p];
				sel_dig_en    = digital_input_enable[p];
				sel_data      = pin_value_register[p];
				sel_level     = pin_level[p];
			end
		end
	end

	// masked read
	// unmasked bits read zero whatever their value; unmapped offsets read zero
	always_comb begin
		read_byte = '0;
		if (hit_data) begin
			read_byte = sel_data & access_mask;
		end else if (hit_dir) begin
			read_byte = sel_dir;
		end else if (hit_afsel) begin
			read_byte = sel_afsel;
		end else if (hit_pull_up) begin
			read_byte = sel_pull_up;
		end else if (hit_pull_down) begin
			read_byte = sel_pull_down;
		end else if (hit_dig_en) begin
			read_byte = sel_dig_en;
		end else if (hit_pin_level) begin
			read_byte = sel_level;
		end
		next_rdata = {{(mgp_pkg::DATA_W-PINS){1'b0}}, read_byte};
	end

	// rdata is zero except in the cycle after a read strobe
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= '0;
		end
	end

endmodule

/* File: test/mgp_top_checker.sv */
// checker for mgp_top: read timing, masked reads, reset defaults, pad causes.
// assumes one clk_sys domain with asynchronous active-low rst_b.
`timescale 1ns/10ps
module mgp_top_checker #(
	parameter int PORTS = 8,
	parameter int PINS  = 8
) (
	input wire logic                       clk_sys,
	input wire logic                       rst_b,
	input wire logic [mgp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic                       reg_wr,
	input wire logic                       reg_rd,
	input wire logic [mgp_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [PORTS*PINS-1:0]      pad_in,
	input wire logic [PORTS*PINS-1:0]      pad_out,
	input wire logic [PORTS*PINS-1:0]      pad_oe_b,
	input wire logic [PORTS*PINS-1:0]      pad_pull_up,
	input wire logic [PORTS*PINS-1:0]      pad_pull_down,
	input wire logic [PORTS*PINS-1:0]      periph_out,
	input wire logic [PORTS*PINS-1:0]      periph_oe,
	input wire logic                       debug_reset_b
);
	// ==========================================================
	// properties
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	AST_MASK_RD: assert property ($past(reg_rd && reg_addr[11:10] == 2'h0) |->
		(reg_rdata[7:0] & ~$past(reg_addr[9:2])) == 8'h00) else $error("masked read bit set");
	AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside slot");
	AST_RD_HI: assert property (reg_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	AST_RST_DEF: assert property ($rose(rst_b) |-> &pad_oe_b && pad_pull_down == 64'h0
		&& pad_pull_up == 64'h0000_0000_000F_8000 && debug_reset_b) else $error("bad reset state");
	AST_DBG_RST: assert property ($fell(debug_reset_b) |-> !$past(pad_in[15], 3)
		|| !$past(pad_in[15], 4) || !$past(pad_in[15], 5)) else $error("debug reset without low pin");
	AST_OE_CAUSE: assert property ($changed(pad_oe_b) |-> $past(reg_wr) || $past(reg_wr, 2)
		|| $past(periph_oe) != $past(periph_oe, 2)) else $error("enable moved alone");
	AST_OUT_CAUSE: assert property ($changed(pad_out & ~pad_oe_b) |-> $past(reg_wr)
		|| $past(reg_wr, 2) || $past(periph_out) != $past(periph_out, 2)
		|| $past(periph_oe) != $past(periph_oe, 2)) else $error("output moved alone");
	AST_PULL_CAUSE: assert property ($changed({pad_pull_up, pad_pull_down}) |->
		$past(reg_wr) || $past(reg_wr, 2)) else $error("pull moved alone");
	COV_WR: cover property (reg_wr && reg_addr[11:10] == 2'h0);
	COV_RD: cover property (reg_rd && reg_addr[11:10] == 2'h0);
	COV_DBG: cover property ($fell(debug_reset_b));
endmodule

bind mgp_top mgp_top_checker #(.PORTS(PORTS), .PINS(PINS)) u_chk (
	.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_b(pad_oe_b),
	.pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .periph_out(periph_out),
	.periph_oe(periph_oe), .debug_reset_b(debug_reset_b));

/* File: test/mgp_pad_model.sv */
// pad wires outside the port: design drive, outside driver, pulls, float.
// assumes the bench supplies an outside driver and a toggling float pattern.
`timescale 1ns/10ps
module mgp_pad_model #(
	parameter int N = 64
) (
	input  wire logic [N-1:0] pad_out,
	input  wire logic [N-1:0] pad_oe_b,
	input  wire logic [N-1:0] pull_up,
	input  wire logic [N-1:0] pull_down,
	input  wire logic [N-1:0] ext_val,
	input  wire logic [N-1:0] ext_en,
	input  wire logic [N-1:0] float_pat,
	output logic      [N-1:0] pad_in
);
	// ==========================================================
	// wire level: design, outside, pull, else a changing pattern
	// pull-up keeps pin high, pull-down keeps it low
	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (!pad_oe_b[i]) pad_in[i] = pad_out[i];
			else if (ext_en[i]) pad_in[i] = ext_val[i];
			else if (pull_up[i]) pad_in[i] = 1'b1;
			else if (pull_down[i]) pad_in[i] = 1'b0;
			else pad_in[i] = float_pat[i];
		end
	end
endmodule

/* File: test/mgp_top_bench.sv */
// self-checking bench for mgp_top with a pad model on the far side.
// assumes the register port answers reads one cycle later.
`timescale 1ns/10ps
module mgp_top_bench;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic [14:0] reg_addr = 15'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [63:0] pad_in, pad_out, pad_oe_b, pad_pull_up, pad_pull_down, periph_in;
	logic [63:0] periph_out = 64'h0;
	logic [63:0] periph_oe = 64'h0;
	logic [63:0] ext_val = 64'h0;
	logic [63:0] ext_en = 64'h0;
	logic [63:0] float_pat = 64'h5555_5555_5555_5555;
	logic        debug_reset_b;
	logic [15:0] lfsr_q = 16'h3E81;
	logic [31:0] exp_q[$];
	logic [31:0] exp_w;
	logic [7:0]  sh, m, d;
	logic        rd_prev = 1'b0;
	int          error_cnt = 0;
	int          n_tests = 0;
	int          k;

	always #4 clk_sys = ~clk_sys;
	// float pattern flips each cycle so a loose pin never looks stable
	always @(posedge clk_sys) float_pat <= ~float_pat;

	mgp_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe_b(pad_oe_b), .pad_pull_up(pad_pull_up),
		.pad_pull_down(pad_pull_down), .periph_out(periph_out), .periph_oe(periph_oe),
		.periph_in(periph_in), .debug_reset_b(debug_reset_b));
	mgp_pad_model u_pad (.pad_out(pad_out), .pad_oe_b(pad_oe_b), .pull_up(pad_pull_up),
		.pull_down(pad_pull_down), .ext_val(ext_val), .ext_en(ext_en), .float_pat(float_pat),
		.pad_in(pad_in));

	// ==========================================================
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [14:0] ad(input int p, input logic [11:0] o);
		return {p[2:0], o};
	endfunction
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one strobe cycle then an idle cycle, so no signal is set twice per step
	task automatic bus(input logic w, input logic [14:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= {24'h0, v};
		reg_wr <= w;
		reg_rd <= !w;
		if (!w) exp_q.push_back({24'h0, v});
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic do_reset();
		rst_b <= 1'b0;
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
	endtask
	task automatic check_defaults();
		logic [7:0] dv;
		for (int p = 0; p < 8; p++) begin
			dv = (p == 1) ? 8'h80 : (p == 2) ? 8'h0F : 8'h00;
			bus(1'b0, ad(p, mgp_pkg::OFF_AFSEL), dv);
			bus(1'b0, ad(p, mgp_pkg::OFF_DIG_EN), dv);
			bus(1'b0, ad(p, mgp_pkg::OFF_PULL_UP), dv);
			bus(1'b0, ad(p, mgp_pkg::OFF_PULL_DOWN), 8'h00);
			bus(1'b0, ad(p, mgp_pkg::OFF_DIR), 8'h00);
		end
		bus(1'b0, ad(0, 12'h3FC), 8'h00);
		@(negedge clk_sys);
		chk(pad_oe_b, 64'hFFFF_FFFF_FFFF_FFFF);
		chk(pad_pull_up, 64'h0000_0000_000F_8000);
		chk(64'(debug_reset_b), 64'h1);
		@(posedge clk_sys);
	endtask
	task automatic print_verdict();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ==========================================================
	// read monitor: oldest note against the data slot
	always @(negedge clk_sys) begin
		if (rd_prev) begin
			exp_w = exp_q.pop_front();
			chk(64'(reg_rdata), 64'(exp_w));
		end
		rd_prev = reg_rd;
	end

	initial begin
		repeat (100000) @(posedge clk_sys);
		error_cnt++;
		print_verdict();
	end

	// ==========================================================
	// main sequence
	initial begin
		do_reset();
		check_defaults();
		bus(1'b1, ad(0, mgp_pkg::OFF_DIR), 8'hFF);
		bus(1'b1, ad(0, mgp_pkg::OFF_DIG_EN), 8'hFF);
		bus(1'b1, ad(0, 12'h3FC), 8'h00);
		sh = 8'h00;
		for (k = 0; k < 40; k++) begin
			lfsr_q = lfsr(lfsr_q);
			m = (k == 0) ? 8'h26 : lfsr_q[7:0];
			d = (k == 0) ? 8'hEB : lfsr_q[15:8];
			bus(1'b1, ad(0, {2'h0, m, 2'h0}), d);
			sh = (sh & ~m) | (d & m);
			@(negedge clk_sys);
			chk(64'(pad_out[7:0]), 64'(sh));
			chk(64'(pad_oe_b[7:0]), 64'h0);
			@(posedge clk_sys);
			bus(1'b0, ad(0, {2'h0, ~m, 2'h0}), sh & ~m);
		end
		for (k = 0; k < 256; k++) begin
			m = k[7:0];
			bus(1'b0, ad(0, {2'h0, m, 2'h0}), sh & m);
		end
		bus(1'b1, ad(3, mgp_pkg::OFF_DIG_EN), 8'hFF);
		for (k = 0; k < 8; k++) begin
			lfsr_q = lfsr(lfsr_q);
			ext_val[31:24] <= lfsr_q[7:0];
			ext_en[31:24] <= 8'hFF;
			repeat (4) @(posedge clk_sys);
			bus(1'b0, ad(3, 12'h3FC), lfsr_q[7:0]);
			chk(64'(periph_in[31:24]), 64'(lfsr_q[7:0]));
			bus(1'b1, ad(3, 12'h3FC), ~lfsr_q[7:0]);
		end
		bus(1'b0, ad(3, mgp_pkg::OFF_PIN_LEVEL), lfsr_q[7:0]);
		bus(1'b1, ad(4, mgp_pkg::OFF_AFSEL), 8'hFF);
		bus(1'b1, ad(4, mgp_pkg::OFF_DIG_EN), 8'hFF);
		lfsr_q = lfsr(lfsr_q);
		periph_out[39:32] <= lfsr_q[7:0];
		periph_oe[39:32] <= lfsr_q[15:8];
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(64'(pad_out[39:32]), 64'(lfsr_q[7:0]));
		chk(64'(pad_oe_b[39:32]), {56'h0, ~lfsr_q[15:8]});
		@(posedge clk_sys);
		lfsr_q = lfsr(lfsr_q);
		bus(1'b1, ad(5, mgp_pkg::OFF_PULL_DOWN), lfsr_q[15:8]);
		bus(1'b0, ad(5, mgp_pkg::OFF_PULL_DOWN), lfsr_q[15:8]);
		@(negedge clk_sys);
		chk(64'(pad_pull_down[47:40]), 64'(lfsr_q[15:8]));
		@(posedge clk_sys);
		ext_en[15] <= 1'b1;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(64'(debug_reset_b), 64'h0);
		@(posedge clk_sys);
		ext_en[15] <= 1'b0;
		repeat (6) @(posedge clk_sys);
		chk(64'(debug_reset_b), 64'h1);
		do_reset();
		check_defaults();
		print_verdict();
	end
endmodule
